// ===== include/sptc_regs.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * serial transfer controller.
 * assumes: included by bare name from the design files under src/.
 */
// Overview of operation
// - as master a transfer starts when software writes the data register and ends when the done flag sets.
// - as slave with phase 0 a transfer runs from select going low until select returns high.
// - as slave with phase 0 the byte is moved and the done flag set at the middle of the eighth clock, transfer still running.
// - as slave with phase 1 the transfer begins at the first clock edge to active level and ends when the done flag sets.
// - a data register write during a transfer raises the write collision flag in either role.
// - with interrupt enable set, done or mode fault with its imask_q bit set raises the interrupt; never while enable is 0 or the global mask is 1.
// - while the system enable is set, port D lines 2 to 5 belong to the serial function.
// - with the system enable clear no transfer runs and no serial pin function is active.
// - as master with direction bit 5 set, port D line 5 is a general output, not the select input.
// - the open drain select applies to all port D lines: 1 open drain, 0 push pull.
`ifndef SPTC_REGS_VH
`define SPTC_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define SPTC_ADDR_CTRL     4'h0
`define SPTC_ADDR_STAT     4'h1
`define SPTC_ADDR_DATA     4'h2
`define SPTC_ADDR_PDIR     4'h3
`define SPTC_ADDR_PDOUT    4'h4
`define SPTC_ADDR_PDIN     4'h5
`define SPTC_ADDR_IMASK    4'h6

// ****************************************************************
// control fields
// ****************************************************************
`define SPTC_CTRL_IE       7
`define SPTC_CTRL_SE       6
`define SPTC_CTRL_OD       5
`define SPTC_CTRL_MSTR     4
`define SPTC_CTRL_CPOL     3
`define SPTC_CTRL_CLOCK_PHASE_SEL     2
`define SPTC_CTRL_RST      8'h04

// ****************************************************************
// status fields
// ****************************************************************
`define SPTC_STAT_DONE     7
`define SPTC_STAT_WCOL     6
`define SPTC_STAT_MODE_FAULT_FLAG     4
`define SPTC_STAT_BUSY     0

// ****************************************************************
// timing: serial clock half period in ns, divided down from 100 ns
// ****************************************************************
`define SPTC_CLK_NS        100
`define SPTC_HALF_NS       400
`define SPTC_HALF_CYC      (`SPTC_HALF_NS / `SPTC_CLK_NS)
`define SPTC_BITS          4'h8

`endif

// ===== src/sptc_shifter.v
/*
 * eight bit shift register, msb first, with parallel load.
 * assumes: sample and shift strobes come one cycle apart from the controller.
 */
`timescale 1ns/1ps
`default_nettype none
module sptc_shifter (
   // clock and reset
   input  wire       ref_clk_in,
   input  wire       sys_rst_in,
   // control
   input  wire       load_in,
   input  wire [7:0] load_data_in,
   input  wire       sample_in,
   input  wire       shift_in,
   input  wire       serial_in,
   // state
   output reg  [7:0] shift_out,
   output reg        bit_q_out
);
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         shift_out <= 8'h00;
         bit_q_out <= 1'b0;
      end else if (load_in) begin
         shift_out <= load_data_in;
      end else begin
         if (sample_in)
            bit_q_out <= serial_in;
         if (shift_in)
            shift_out <= {shift_out[6:0], bit_q_out};
      end
   end
endmodule
`default_nettype wire

// ===== src/sptc_sync2.v
/*
 * two flip-flop synchroniser for one level from outside the clock domain.
 * assumes: nothing reads the first stage except the second.
 */
`timescale 1ns/1ps
`default_nettype none
module sptc_sync2 (
   // clock and reset
   input  wire ref_clk_in,
   input  wire sys_rst_in,
   // level
   input  wire d_in,
   output reg  q_out
);
   reg meta_q;
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_q <= 1'b0;
         q_out  <= 1'b0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== src/sptc_top.v
/*
 * serial transfer controller: master or slave byte transfers over port D
 * lines 2..5 (miso, mosi, sck, select), register port, status interrupt.
 * assumes: register strobes on ref_clk_in; all pins are asynchronous and
 * are synchronised here; the pad logic resolves pin levels from enables.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sptc_regs.vh"
module sptc_top (
   // clock and reset
   input  wire       ref_clk_in,
   input  wire       sys_rst_in,
   // register port
   input  wire [3:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   // processor
   input  wire       cpu_irq_mask_in,
   output reg        irq_out,
   // port D pads
   input  wire [5:0] portd_pin_in,
   output reg  [5:0] portd_pin_out,
   output reg  [5:0] portd_pin_oe_out
);
   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_TAIL = 3'b100;
   localparam [31:0] HALF_FULL = `SPTC_HALF_CYC;
   localparam [7:0]  HALF_CYC  = HALF_FULL[7:0];

   function is_wr;
      input [3:0] a;
      begin
         is_wr = reg_wr_in && (reg_addr_in == a);
      end
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   reg  [7:0] ctrl_q;
   reg  [5:0] pdir_q;
   reg  [5:0] pdout_q;
   reg  [7:0] rxbuf_q;
   reg  [7:0] imask_q;
   reg        done_q, wcol_q, mode_fault_flag_q;
   reg  [2:0] st_q;
   reg  [3:0] bit_cnt_q;
   reg  [7:0] div_q;
   reg        sck_int_q;
   reg        sck_prev_q;
   reg        ss_prev_q;
   reg        shift_pend_q;
   wire [5:0] pin_s;
   wire [7:0] shreg;
   wire       rx_bit;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         sptc_sync2 u_sync (
            .ref_clk_in (ref_clk_in),
            .sys_rst_in (sys_rst_in),
            .d_in       (portd_pin_in[gi]),
            .q_out      (pin_s[gi])
         );
      end
   endgenerate

   wire enable  = ctrl_q[`SPTC_CTRL_SE];
   wire master  = ctrl_q[`SPTC_CTRL_MSTR];
   wire cpol    = ctrl_q[`SPTC_CTRL_CPOL];
   wire clock_phase_sel    = ctrl_q[`SPTC_CTRL_CLOCK_PHASE_SEL];
   wire busy    = (st_q != ST_IDLE);
   // line 5 is a plain output for a master with direction bit 5 set
   wire ss_gpo  = master && pdir_q[5];
   wire ss_n    = (enable && !ss_gpo) ? pin_s[5] : 1'b1;
   wire sck_in  = pin_s[4];
   wire sck_act = master ? (sck_int_q ^ cpol) : (sck_in ^ cpol);
   wire sck_p   = master ? (sck_prev_q ^ cpol) : (sck_prev_q ^ cpol);
   wire sck_now = master ? sck_int_q : sck_in;
   wire lead    = sck_act && !sck_p;
   wire trail   = !sck_act && sck_p && (sck_now != sck_prev_q);
   wire lead_e  = lead && (sck_now != sck_prev_q);
   // phase 0 samples on leading, phase 1 on trailing edges
   wire samp_e  = busy && (clock_phase_sel ? trail : lead_e);
   wire data_wr = is_wr(`SPTC_ADDR_DATA);
   wire m_start = enable && master && data_wr && !busy;
   wire s_start = enable && !master && !busy &&
                  (clock_phase_sel ? (!ss_n && lead_e)
                        : (!ss_n && ss_prev_q));
   wire mfault  = enable && master && !ss_gpo && !ss_n;
   wire byte_done = samp_e && (bit_cnt_q == 4'h7);
   wire miso_in = master ? pin_s[2] : pin_s[3];

   sptc_shifter u_shift (
      .ref_clk_in   (ref_clk_in),
      .sys_rst_in   (sys_rst_in),
      .load_in      (m_start || (!master && !busy && data_wr)),
      .load_data_in (reg_wdata_in),
      .sample_in    (samp_e),
      .shift_in     (shift_pend_q),
      .serial_in    (miso_in),
      .shift_out    (shreg),
      .bit_q_out    (rx_bit)
   );

   // ****************************************************************
   // transfer state machine
   // ****************************************************************
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q         <= ST_IDLE;
         bit_cnt_q    <= 4'h0;
         div_q        <= 8'h00;
         sck_int_q    <= 1'b0;
         sck_prev_q   <= 1'b0;
         ss_prev_q    <= 1'b1;
         shift_pend_q <= 1'b0;
      end else begin
         sck_prev_q   <= sck_now;
         ss_prev_q    <= ss_n;
         shift_pend_q <= samp_e;
         if (!enable || mfault) begin
            st_q      <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            sck_int_q <= 1'b0;
            div_q     <= 8'h00;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  sck_int_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  div_q     <= 8'h00;
                  if (m_start || s_start)
                     st_q <= ST_RUN;
               end
               ST_RUN: begin
                  if (master) begin
                     if (div_q == HALF_CYC - 8'h01) begin
                        div_q <= 8'h00;
                        if (!(clock_phase_sel == 1'b0 && bit_cnt_q == `SPTC_BITS))
                           sck_int_q <= ~sck_int_q;
                     end else begin
                        div_q <= div_q + 8'h01;
                     end
                  end
                  if (samp_e)
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  // eighth sample ends a master or phase 1 slave
                  if (byte_done)
                     st_q <= (!master && !clock_phase_sel) ? ST_TAIL : ST_IDLE;
               end
               ST_TAIL: begin
                  if (ss_n)
                     st_q <= ST_IDLE;
               end
               default: st_q <= ST_IDLE;
            endcase
            // slave phase 0: select released early aborts the byte
            if (!master && !clock_phase_sel && ss_n && st_q == ST_RUN)
               st_q <= ST_IDLE;
         end
      end
   end

   // ****************************************************************
   // control and status registers
   // ****************************************************************
   wire done_set = shift_pend_q && (bit_cnt_q == `SPTC_BITS) && enable;
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q  <= `SPTC_CTRL_RST;
         pdir_q  <= 6'h00;
         pdout_q <= 6'h00;
         rxbuf_q <= 8'h00;
         imask_q <= 8'hff;
         done_q  <= 1'b0;
         wcol_q  <= 1'b0;
         mode_fault_flag_q  <= 1'b0;
      end else begin
         if (is_wr(`SPTC_ADDR_CTRL))
            ctrl_q <= reg_wdata_in;
         if (is_wr(`SPTC_ADDR_PDIR))
            pdir_q <= reg_wdata_in[5:0];
         if (is_wr(`SPTC_ADDR_PDOUT))
            pdout_q <= reg_wdata_in[5:0];
         if (is_wr(`SPTC_ADDR_IMASK))
            imask_q <= reg_wdata_in;
         // byte moves to the read buffer as the last bit is shifted in
         if (done_set) begin
            rxbuf_q <= {shreg[6:0], rx_bit};
         end
         // flags clear by writing one; a set in the same cycle wins
         done_q <= done_set | (done_q &
                   ~(is_wr(`SPTC_ADDR_STAT) & reg_wdata_in[`SPTC_STAT_DONE]));
         wcol_q <= (data_wr & busy) | (wcol_q &
                   ~(is_wr(`SPTC_ADDR_STAT) & reg_wdata_in[`SPTC_STAT_WCOL]));
         mode_fault_flag_q <= mfault | (mode_fault_flag_q &
                   ~(is_wr(`SPTC_ADDR_STAT) & reg_wdata_in[`SPTC_STAT_MODE_FAULT_FLAG]));
         if (mfault) begin
            ctrl_q[`SPTC_CTRL_SE]   <= 1'b0;
            ctrl_q[`SPTC_CTRL_MSTR] <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // read port, interrupt and pads
   // ****************************************************************
   wire [7:0] stat = {done_q, wcol_q, 1'b0, mode_fault_flag_q, 3'b000, busy};
   reg  [7:0] rd_d;
   always @* begin
      case (reg_addr_in)
         `SPTC_ADDR_CTRL:  rd_d = ctrl_q;
         `SPTC_ADDR_STAT:  rd_d = stat;
         `SPTC_ADDR_DATA:  rd_d = rxbuf_q;
         `SPTC_ADDR_PDIR:  rd_d = {2'b00, pdir_q};
         `SPTC_ADDR_PDOUT: rd_d = {2'b00, pdout_q};
         `SPTC_ADDR_PDIN:  rd_d = {2'b00, pin_s};
         `SPTC_ADDR_IMASK: rd_d = imask_q;
         default:          rd_d = 8'h00;
      endcase
   end

   // serial function drives: 2 miso (slave), 3 mosi (master), 4 sck (master)
   reg [5:0] val_d;
   reg [5:0] drv_d;
   always @* begin
      val_d = pdout_q;
      drv_d = pdir_q;
      if (enable) begin
         val_d[2] = shreg[7];
         drv_d[2] = !master && !ss_n;
         val_d[3] = shreg[7];
         drv_d[3] = master;
         val_d[4] = sck_int_q ^ cpol;
         drv_d[4] = master;
         drv_d[5] = ss_gpo;
      end
   end

   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out    <= 8'h00;
         irq_out          <= 1'b0;
         portd_pin_out    <= 6'h00;
         portd_pin_oe_out <= 6'h00;
      end else begin
         reg_rdata_out <= reg_rd_in ? rd_d : 8'h00;
         irq_out <= ctrl_q[`SPTC_CTRL_IE] && !cpu_irq_mask_in &&
                    |((stat & 8'h90) & imask_q);
         portd_pin_out <= val_d;
         // open drain drives only lows; a high is released
         if (ctrl_q[`SPTC_CTRL_OD])
            portd_pin_oe_out <= drv_d & ~val_d;
         else
            portd_pin_oe_out <= drv_d;
      end
   end
endmodule
`default_nettype wire

// ===== tb/sptc_asserts.sv
/*
 * checker for the serial transfer controller, seeing only the top ports.
 * assumes: control, direction and output values change only by register
 * writes, apart from a mode fault, which the bench lets happen only with
 * the select line low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sptc_regs.vh"
module sptc_checker (
   input wire logic       ref_clk_in,
   input wire logic       sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       cpu_irq_mask_in,
   input wire logic       irq_out,
   input wire logic [5:0] portd_pin_in,
   input wire logic [5:0] portd_pin_out,
   input wire logic [5:0] portd_pin_oe_out
);
   logic [7:0] ctrl_q;
   logic [5:0] dir_q;
   logic [5:0] out_q;
   logic [1:0] quiet_q;
   logic [2:0] sel_q;
   logic [5:0] exp_oe;
   // open drain lines are enabled only while pulling low
   assign exp_oe = ctrl_q[`SPTC_CTRL_OD] ? (dir_q & ~out_q) : dir_q;
   always @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q <= `SPTC_CTRL_RST;
         dir_q <= 6'h00;
         out_q <= 6'h00;
         quiet_q <= 2'h0;
         sel_q <= 3'h0;
      end else begin
         if (reg_wr_in && reg_addr_in == `SPTC_ADDR_CTRL) ctrl_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `SPTC_ADDR_PDIR) dir_q <= reg_wdata_in[5:0];
         if (reg_wr_in && reg_addr_in == `SPTC_ADDR_PDOUT) out_q <= reg_wdata_in[5:0];
         if (reg_wr_in) quiet_q <= 2'h0;
         else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
         if (!portd_pin_in[5]) sel_q <= 3'h0;
         else if (sel_q != 3'h7) sel_q <= sel_q + 3'h1;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   gpio_bits_a: assert property (quiet_q == 2'h3 |-> portd_pin_oe_out[1:0] == exp_oe[1:0])
      else $error("plain port line drive enable wrong");
   open_drain_a: assert property (quiet_q == 2'h3 && ctrl_q[`SPTC_CTRL_OD]
      |-> (portd_pin_oe_out & portd_pin_out) == 6'h00) else $error("open drain line driven high");
   disabled_pins_a: assert property (quiet_q == 2'h3 && !ctrl_q[`SPTC_CTRL_SE]
      |-> portd_pin_oe_out[5:2] == exp_oe[5:2]) else $error("serial lines active while off");
   serial_pins_a: assert property (quiet_q == 2'h3 && ctrl_q[`SPTC_CTRL_SE] && sel_q == 3'h7
      && ctrl_q[`SPTC_CTRL_MSTR] && !ctrl_q[`SPTC_CTRL_OD] |-> portd_pin_oe_out[4:2] == 3'b110)
      else $error("master serial lines not driven");
   select_gpio_a: assert property (quiet_q == 2'h3 && ctrl_q[`SPTC_CTRL_SE] && dir_q[5]
      && ctrl_q[`SPTC_CTRL_MSTR] && !ctrl_q[`SPTC_CTRL_OD]
      |-> portd_pin_oe_out[5] && portd_pin_out[5] == out_q[5]) else $error("select not an output");
   cpu_mask_a: assert property (cpu_irq_mask_in && $past(cpu_irq_mask_in) |-> !irq_out)
      else $error("interrupt while masked");
   irq_enable_a: assert property (!ctrl_q[`SPTC_CTRL_IE] && !$past(ctrl_q[`SPTC_CTRL_IE])
      |-> !irq_out) else $error("interrupt while disabled");
   master_start_a: assert property (reg_wr_in && reg_addr_in == `SPTC_ADDR_DATA && sel_q == 3'h7
      && ctrl_q[`SPTC_CTRL_SE] && ctrl_q[`SPTC_CTRL_MSTR] |-> ##[1:12] $changed(portd_pin_out[4]))
      else $error("master write did not start clock");
endmodule
bind sptc_top sptc_checker chk_i (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cpu_irq_mask_in, .irq_out, .portd_pin_in,
   .portd_pin_out, .portd_pin_oe_out);
`default_nettype wire

// ===== tb/sptc_far_slave.sv
/*
 * far side slave: clock phase 1, clock idle low, msb first.
 * assumes: the bench hands it resolved clock and data line levels.
 */
`timescale 1ns/1ps
`default_nettype none
module sptc_far_slave (
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic [7:0] tx_in,
   output var  logic       miso_out,
   output var  logic [7:0] rx_out
);
   int n = 0;
   initial miso_out = 1'b0;
   initial rx_out = 8'h00;
   always @(posedge sck_in) miso_out = tx_in[7 - n];
   // after the eighth bit the line is inverted, so it does not keep the last bit's value
   always @(negedge sck_in) begin
      rx_out = {rx_out[6:0], mosi_in};
      n = (n == 7) ? 0 : n + 1;
      if (n == 0) miso_out = ~miso_out;
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/*
 * testbench of the serial transfer controller: register tasks, far slave,
 * bit-banged master for slave mode.
 * assumes: pad levels are resolved here from the design's drive enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sptc_regs.vh"
module testbench;
   logic       ref_clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic [3:0] reg_addr_in = 4'h0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   logic       cpu_irq_mask_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic       irq_out;
   logic [5:0] portd_pin_in;
   logic [5:0] portd_pin_out;
   logic [5:0] portd_pin_oe_out;
   logic [5:0] ext = 6'h2b;
   logic       miso;
   logic [7:0] far_rx;
   int         n_mismatch = 0;
   int         compares = 0;
   int         cyc = 0;
   always #50 ref_clk_in = ~ref_clk_in;
   // undriven lines fall back to the far slave on line 2 or to the bench levels in ext
   assign portd_pin_in = (portd_pin_oe_out & portd_pin_out)
                       | (~portd_pin_oe_out & {ext[5:3], miso, ext[1:0]});
   sptc_top uut (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .cpu_irq_mask_in, .irq_out, .portd_pin_in,
      .portd_pin_out, .portd_pin_oe_out);
   sptc_far_slave far (.sck_in(portd_pin_in[4]), .mosi_in(portd_pin_in[3]), .tx_in(8'h3c),
      .miso_out(miso), .rx_out(far_rx));
   task automatic finish_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test;
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e, input string name);
      logic [7:0] v;
      rd(a, v);
      chk(name, e, v);
   endtask
   task automatic wait_done;
      logic [7:0] s = 8'h00;
      for (int i = 0; i < 60 && s[7] !== 1'b1; i++)
         rd(`SPTC_ADDR_STAT, s);
      chk("done flag", 8'h80, s & 8'h80);
   endtask
   // bench as serial master; select is left low for the caller to release
   task automatic link_byte(input logic [7:0] b, input logic clock_phase_sel, input int nbits);
      ext[5] = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         if (!clock_phase_sel) ext[3] = b[7 - i];
         #400 ext[4] = 1'b1;
         if (clock_phase_sel) ext[3] = b[7 - i];
         #400 ext[4] = 1'b0;
      end
      #800;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rc(`SPTC_ADDR_CTRL, 8'h04, "ctrl reset");
      rc(`SPTC_ADDR_IMASK, 8'hff, "mask reset");
      rc(`SPTC_ADDR_STAT, 8'h00, "status reset");
      rc(4'h7, 8'h00, "unmapped");
      chk("pads off", 8'h00, {2'b00, portd_pin_oe_out});
      wr(`SPTC_ADDR_PDIR, 8'h3f);
      wr(`SPTC_ADDR_PDOUT, 8'h2a);
      wr(`SPTC_ADDR_CTRL, 8'h20);
      wr(`SPTC_ADDR_DATA, 8'h77);
      repeat (4) @(posedge ref_clk_in);
      chk("open drain oe", 8'h15, {2'b00, portd_pin_oe_out});
      rc(`SPTC_ADDR_STAT, 8'h00, "no start when off");
      wr(`SPTC_ADDR_CTRL, 8'h00);
      repeat (4) @(posedge ref_clk_in);
      chk("push pull oe", 8'h3f, {2'b00, portd_pin_oe_out});
      chk("push pull out", 8'h2a, {2'b00, portd_pin_out});
      wr(`SPTC_ADDR_PDIR, 8'h00);
      wr(`SPTC_ADDR_CTRL, 8'hd4);
      wr(`SPTC_ADDR_DATA, 8'ha5);
      wr(`SPTC_ADDR_DATA, 8'h11);
      chk("serial pads", 8'h06, {5'h00, portd_pin_oe_out[4:2]});
      wait_done;
      rc(`SPTC_ADDR_STAT, 8'hc0, "done and collision");
      rc(`SPTC_ADDR_DATA, 8'h3c, "master rx");
      chk("far rx", 8'ha5, far_rx);
      chk("irq", 8'h01, {7'h00, irq_out});
      cpu_irq_mask_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      chk("irq masked", 8'h00, {7'h00, irq_out});
      cpu_irq_mask_in <= 1'b0;
      wr(`SPTC_ADDR_STAT, 8'hc0);
      repeat (2) @(posedge ref_clk_in);
      chk("irq cleared", 8'h00, {7'h00, irq_out});
      wr(`SPTC_ADDR_CTRL, 8'h54);
      wr(`SPTC_ADDR_DATA, 8'h0f);
      wait_done;
      chk("irq disabled", 8'h00, {7'h00, irq_out});
      chk("far rx 2", 8'h0f, far_rx);
      wr(`SPTC_ADDR_STAT, 8'h80);
      wr(`SPTC_ADDR_CTRL, 8'hd4);
      wr(`SPTC_ADDR_PDIR, 8'h20);
      wr(`SPTC_ADDR_PDOUT, 8'h20);
      ext[5] = 1'b0;
      repeat (6) @(posedge ref_clk_in);
      chk("select pad", 8'h03, {6'h00, portd_pin_oe_out[5], portd_pin_out[5]});
      rc(`SPTC_ADDR_STAT, 8'h00, "no fault");
      wr(`SPTC_ADDR_PDIR, 8'h00);
      repeat (6) @(posedge ref_clk_in);
      rc(`SPTC_ADDR_STAT, 8'h10, "mode fault");
      rc(`SPTC_ADDR_CTRL, 8'h84, "fault ctrl");
      chk("fault irq", 8'h01, {7'h00, irq_out});
      wr(`SPTC_ADDR_CTRL, 8'h40);
      wr(`SPTC_ADDR_STAT, 8'h10);
      ext[5] = 1'b1;
      #800 link_byte(8'h96, 1'b0, 8);
      rc(`SPTC_ADDR_STAT, 8'h81, "slave done");
      rc(`SPTC_ADDR_DATA, 8'h96, "slave rx");
      ext[5] = 1'b1;
      wr(`SPTC_ADDR_STAT, 8'h80);
      #800 link_byte(8'hf0, 1'b0, 4);
      ext[5] = 1'b1;
      #800 rc(`SPTC_ADDR_STAT, 8'h00, "abort no done");
      wr(`SPTC_ADDR_CTRL, 8'h44);
      #800 link_byte(8'h5a, 1'b1, 8);
      rc(`SPTC_ADDR_STAT, 8'h80, "phase 1 done");
      rc(`SPTC_ADDR_DATA, 8'h5a, "phase 1 rx");
      ext[5] = 1'b1;
      finish_test;
   end
endmodule
`default_nettype wire
